// File: hw/psc_pkg.sv
// Package of constants and types for the panel status and port config block
package psc_pkg;
    // Blink timing
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned BLINK_ON_MS     = 250;
    localparam int unsigned BLINK_PAUSE_MS  = 1000;
    localparam int unsigned BLINK_ON_CYC    = CLK_HZ / 1000 * BLINK_ON_MS;
    localparam int unsigned BLINK_PAUSE_CYC = CLK_HZ / 1000 * BLINK_PAUSE_MS;

    // Address limits
    localparam logic [6:0] ADDR_MIN = 7'h01;
    localparam logic [6:0] ADDR_MAX = 7'h40;
    localparam logic [3:0] DIGIT_MAX = 4'h9;

    // Fixed framing values
    localparam logic [14:0] BAUD_ASCII = 15'h0960;
    localparam logic [14:0] BAUD_RTU   = 15'h2580;
    localparam logic [3:0]  BITS_ASCII = 4'h7;
    localparam logic [3:0]  BITS_RTU   = 4'h8;
    localparam logic [1:0]  STOP_ONE   = 2'h1;
    localparam logic [1:0]  STOP_TWO   = 2'h2;
    localparam logic [7:0]  SW_ADDR_MAX = 8'hF7;

    // Blink counts per fatal group
    localparam logic [3:0] BLINKS_CONT = 4'h0;
    localparam logic [3:0] BLINKS_MEM  = 4'h2;
    localparam logic [3:0] BLINKS_BUS  = 4'h3;
    localparam logic [3:0] BLINKS_COMM = 4'h4;
    localparam logic [3:0] BLINKS_RAMA = 4'h5;
    localparam logic [3:0] BLINKS_RAMD = 4'h6;
    localparam logic [3:0] BLINKS_EXEC = 4'h7;
    localparam logic [3:0] BLINKS_PROM = 4'h8;

    // Crash codes
    localparam logic [15:0] CC_KERNEL    = 16'h0000;
    localparam logic [15:0] CC_MEM_SIZE  = 16'h080B;
    localparam logic [15:0] CC_RUN_OUT   = 16'h080C;
    localparam logic [15:0] CC_STACK     = 16'h082E;
    localparam logic [15:0] CC_BUS_GRANT = 16'h0769;
    localparam logic [15:0] CC_BUS_LO    = 16'h072A;
    localparam logic [15:0] CC_BUS_HI    = 16'h0730;
    localparam logic [15:0] CC_COMM_LO   = 16'h0604;
    localparam logic [15:0] CC_COMM_HI   = 16'h0631;
    localparam logic [15:0] CC_RAM_ADDR  = 16'h0503;
    localparam logic [15:0] CC_POST_MPU  = 16'h052D;
    localparam logic [15:0] CC_RAM_DATA  = 16'h0402;
    localparam logic [15:0] CC_EXEC_NONE = 16'h0300;
    localparam logic [15:0] CC_EXEC_SUM  = 16'h0301;
    localparam logic [15:0] CC_PROM_SUM  = 16'h8001;
    localparam logic [15:0] CC_FLASH     = 16'h8002;
    localparam logic [15:0] CC_EXEC_RET  = 16'h8003;

    // Three-position switch codes
    typedef enum logic [1:0] {
        PSC_POS_TOP    = 2'h0,
        PSC_POS_MIDDLE = 2'h1,
        PSC_POS_BOTTOM = 2'h2
    } psc_pos_e;

    typedef enum logic [1:0] {
        PSC_PAR_NONE = 2'h0,
        PSC_PAR_ODD  = 2'h1,
        PSC_PAR_EVEN = 2'h2
    } psc_par_e;

    typedef struct packed {
        logic       ready;
        logic       run;
        logic       serial_act;
        logic       net_act;
        logic       mem_protect;
        logic       bat_low;
        logic       net_err;
    } psc_lamps_s;

    typedef struct packed {
        logic [14:0] baud;
        psc_par_e    parity;
        logic [3:0]  data_bits;
        logic [1:0]  stop_bits;
        logic [7:0]  address;
    } psc_port_s;
endpackage

// File: hw/psc_panel.sv
// Front-panel lamps, blink codes, slide and rotary switch decoding
//
// Notes on behaviour
// - Ready lamp only after diagnostics pass.
// - Run lamp while program executes.
// - Serial lamp on during serial traffic.
// - Network lamp on during network traffic.
// - Amber lamp when memory writes blocked.
// - Red lamp when battery needs replacing.
// - Red lamp on network communication error.
// - Fatal group blinks run lamp; kernel continuous.
// - Two blinks: codes 80B, 80C, 82E.
// - Three blinks: codes 769, 72A-730.
// - Four blinks: codes 604 through 631.
// - Five blinks: codes 503 and 52D.
// - Six blinks 402; seven blinks 300/301.
// - Eight blinks: codes 8001, 8002, 8003.
// - Left switch top protects memory.
// - Right top: ASCII 2400 7E1, rotary address.
// - Right middle: RTU 9600 8E1, rotary address.
// - Right bottom: validated software port parameters.
// - Bridge mode when RTU or ASCII.
// - Rotary switches give tens and ones.
// - Address 0 or above 64 holds net lamp.
`timescale 1ns/1ps
module psc_panel (
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic                 diag_passed,
    input  wire logic                 program_running,
    input  wire logic                 serial_traffic,
    input  wire logic                 network_traffic,
    input  wire logic                 battery_low,
    input  wire logic                 network_error,
    input  wire logic                 fatal_error,
    input  wire logic [15:0]          crash_code,
    input  wire logic [1:0]           protect_switch,
    input  wire logic [1:0]           comm_switch,
    input  wire logic [3:0]           tens_address_switch,
    input  wire logic [3:0]           ones_address_switch,
    input  wire psc_pkg::psc_port_s   sw_port_cfg,
    output psc_pkg::psc_lamps_s       lamps,
    output logic                      mem_write_block,
    output psc_pkg::psc_port_s        port_cfg,
    output logic                      sw_cfg_invalid,
    output logic                      bridge_mode,
    output logic [6:0]                node_address,
    output logic                      address_invalid,
    output logic [3:0]                blink_count
);
    typedef enum logic [1:0] {
        PSC_ST_IDLE,
        PSC_ST_ON,
        PSC_ST_OFF,
        PSC_ST_PAUSE
    } psc_blink_e;

    function automatic logic in_range(input logic [15:0] v,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    function automatic logic baud_ok(input logic [14:0] b);
        case (b)
            15'h4B00, 15'h2580, 15'h1C20, 15'h12C0, 15'h0E10,
            15'h0960, 15'h07D0, 15'h0708, 15'h04B0, 15'h0258,
            15'h012C, 15'h0096, 15'h0086, 15'h006E, 15'h004B,
            15'h0032: baud_ok = 1'b1;
            default:  baud_ok = 1'b0;
        endcase
    endfunction

    // Group selection from crash code
    logic [3:0] group_blinks;
    wire cc_mem  = (crash_code == psc_pkg::CC_MEM_SIZE)
                 || (crash_code == psc_pkg::CC_RUN_OUT)
                 || (crash_code == psc_pkg::CC_STACK);
    wire cc_bus  = (crash_code == psc_pkg::CC_BUS_GRANT)
                 || in_range(crash_code, psc_pkg::CC_BUS_LO,
                             psc_pkg::CC_BUS_HI);
    wire cc_comm = in_range(crash_code, psc_pkg::CC_COMM_LO,
                            psc_pkg::CC_COMM_HI);
    wire cc_rama = (crash_code == psc_pkg::CC_RAM_ADDR)
                 || (crash_code == psc_pkg::CC_POST_MPU);
    wire cc_ramd = (crash_code == psc_pkg::CC_RAM_DATA);
    wire cc_exec = (crash_code == psc_pkg::CC_EXEC_NONE)
                 || (crash_code == psc_pkg::CC_EXEC_SUM);
    wire cc_prom = in_range(crash_code, psc_pkg::CC_PROM_SUM,
                            psc_pkg::CC_EXEC_RET);
    assign group_blinks = cc_mem  ? psc_pkg::BLINKS_MEM  :
                          cc_bus  ? psc_pkg::BLINKS_BUS  :
                          cc_comm ? psc_pkg::BLINKS_COMM :
                          cc_rama ? psc_pkg::BLINKS_RAMA :
                          cc_ramd ? psc_pkg::BLINKS_RAMD :
                          cc_exec ? psc_pkg::BLINKS_EXEC :
                          cc_prom ? psc_pkg::BLINKS_PROM :
                                    psc_pkg::BLINKS_CONT;

    // Blink sequencer
    psc_blink_e  state_r;
    logic [31:0] timer_r;
    logic [3:0]  left_r;
    logic [3:0]  count_r;
    wire         timer_done = (timer_r == 32'h0);
    wire [31:0]  on_load    = 32'(psc_pkg::BLINK_ON_CYC - 1);
    wire [31:0]  pause_load = 32'(psc_pkg::BLINK_PAUSE_CYC - 1);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_r <= PSC_ST_IDLE;
            timer_r <= 32'h0;
            left_r  <= 4'h0;
            count_r <= 4'h0;
        end else if (!fatal_error) begin
            state_r <= PSC_ST_IDLE;
            timer_r <= 32'h0;
            left_r  <= 4'h0;
            count_r <= 4'h0;
        end else if (state_r == PSC_ST_IDLE || timer_done) begin
            case (state_r)
                PSC_ST_IDLE, PSC_ST_PAUSE: begin
                    state_r <= PSC_ST_ON;
                    timer_r <= on_load;
                    count_r <= group_blinks;
                    left_r  <= group_blinks;
                end
                PSC_ST_ON: begin
                    state_r <= PSC_ST_OFF;
                    timer_r <= on_load;
                    if (left_r != 4'h0) begin
                        left_r <= left_r - 4'h1;
                    end
                end
                default: begin
                    // Continuous group never pauses
                    if (left_r == 4'h0 && count_r != 4'h0) begin
                        state_r <= PSC_ST_PAUSE;
                        timer_r <= pause_load;
                    end else begin
                        state_r <= PSC_ST_ON;
                        timer_r <= on_load;
                    end
                end
            endcase
        end else begin
            timer_r <= timer_r - 32'h1;
        end
    end
    assign blink_count = count_r;

    // Switch decoding
    wire tens_ok = (tens_address_switch <= psc_pkg::DIGIT_MAX);
    wire ones_ok = (ones_address_switch <= psc_pkg::DIGIT_MAX);
    wire [6:0] addr_sum = 7'(tens_address_switch * 4'hA)
                        + 7'(ones_address_switch);
    wire addr_bad = !tens_ok || !ones_ok
                  || (addr_sum < psc_pkg::ADDR_MIN)
                  || (addr_sum > psc_pkg::ADDR_MAX);
    wire protect  = (protect_switch == psc_pkg::PSC_POS_TOP);
    wire is_ascii = (comm_switch == psc_pkg::PSC_POS_TOP);
    wire is_rtu   = (comm_switch == psc_pkg::PSC_POS_MIDDLE);
    wire sw_ok = baud_ok(sw_port_cfg.baud)
               && (sw_port_cfg.data_bits == psc_pkg::BITS_ASCII
                   || sw_port_cfg.data_bits == psc_pkg::BITS_RTU)
               && (sw_port_cfg.stop_bits == psc_pkg::STOP_ONE
                   || sw_port_cfg.stop_bits == psc_pkg::STOP_TWO)
               && (sw_port_cfg.parity != 2'h3)
               && (sw_port_cfg.address >= 8'h01)
               && (sw_port_cfg.address <= psc_pkg::SW_ADDR_MAX);

    psc_pkg::psc_port_s fixed_cfg;
    always_comb begin
        fixed_cfg.parity    = psc_pkg::PSC_PAR_EVEN;
        fixed_cfg.stop_bits = psc_pkg::STOP_ONE;
        fixed_cfg.address   = {1'b0, addr_sum};
        if (is_ascii) begin
            fixed_cfg.baud      = psc_pkg::BAUD_ASCII;
            fixed_cfg.data_bits = psc_pkg::BITS_ASCII;
        end else begin
            fixed_cfg.baud      = psc_pkg::BAUD_RTU;
            fixed_cfg.data_bits = psc_pkg::BITS_RTU;
        end
    end

    wire run_lamp = fatal_error ? (state_r == PSC_ST_ON)
                                : program_running;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            lamps           <= '0;
            mem_write_block <= 1'b0;
            port_cfg        <= '0;
            sw_cfg_invalid  <= 1'b0;
            bridge_mode     <= 1'b0;
            node_address    <= 7'h0;
            address_invalid <= 1'b0;
        end else begin
            lamps.ready       <= diag_passed;
            lamps.run         <= run_lamp;
            lamps.serial_act  <= serial_traffic;
            lamps.net_act     <= network_traffic || addr_bad;
            lamps.mem_protect <= protect;
            lamps.bat_low     <= battery_low;
            lamps.net_err     <= network_error;
            mem_write_block   <= protect;
            bridge_mode       <= is_ascii || is_rtu;
            node_address      <= addr_sum;
            address_invalid   <= addr_bad;
            sw_cfg_invalid    <= !(is_ascii || is_rtu) && !sw_ok;
            if (is_ascii || is_rtu) begin
                port_cfg <= fixed_cfg;
            end else if (sw_ok) begin
                port_cfg <= sw_port_cfg;
            end
        end
    end

    // Edge of reset release still shows reset values, so skip it
    property p_ready;
        @(posedge sys_clk) disable iff (reset)
        !reset |=> (lamps.ready == $past(diag_passed));
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready lamp wrong");

    property p_run;
        @(posedge sys_clk) disable iff (reset)
        !reset && !fatal_error |=> (lamps.run == $past(program_running));
    endproperty
    a_run: assert property (p_run)
        else $error("run lamp wrong");

    property p_serial;
        @(posedge sys_clk) disable iff (reset)
        !reset && serial_traffic |=> lamps.serial_act;
    endproperty
    a_serial: assert property (p_serial)
        else $error("serial lamp");

    property p_net;
        @(posedge sys_clk) disable iff (reset)
        !reset && network_traffic |=> lamps.net_act;
    endproperty
    a_net: assert property (p_net)
        else $error("net lamp off");

    property p_protect;
        @(posedge sys_clk) disable iff (reset)
        !reset && (protect_switch == psc_pkg::PSC_POS_TOP) |=>
            (lamps.mem_protect && mem_write_block);
    endproperty
    a_protect: assert property (p_protect)
        else $error("no protect");

    property p_unprotect;
        @(posedge sys_clk) disable iff (reset)
        !reset && (protect_switch != psc_pkg::PSC_POS_TOP) |=>
            (!lamps.mem_protect && !mem_write_block);
    endproperty
    a_unprotect: assert property (p_unprotect)
        else $error("memory protected");

    property p_batnet;
        @(posedge sys_clk) disable iff (reset)
        !reset |=> (lamps.bat_low == $past(battery_low))
              && (lamps.net_err == $past(network_error));
    endproperty
    a_batnet: assert property (p_batnet)
        else $error("red lamps");

    // Fault raised and held: run lamp lit two edges later
    sequence s_blink_start;
        !fatal_error ##1 fatal_error;
    endsequence
    property p_blink_start;
        @(posedge sys_clk) disable iff (reset)
        s_blink_start ##1 fatal_error |->
            (state_r == PSC_ST_ON) ##1 lamps.run;
    endproperty
    a_blink_start: assert property (p_blink_start)
        else $error("blink not started");

    property p_kernel;
        @(posedge sys_clk) disable iff (reset)
        (state_r == PSC_ST_OFF && count_r == 4'h0 && timer_done
         && fatal_error) |=> (state_r == PSC_ST_ON);
    endproperty
    a_kernel: assert property (p_kernel)
        else $error("continuous blink paused");

    property p_pause_after;
        @(posedge sys_clk) disable iff (reset)
        (state_r == PSC_ST_OFF && left_r == 4'h0 && count_r != 4'h0
         && timer_done && fatal_error) |=> (state_r == PSC_ST_PAUSE);
    endproperty
    a_pause_after: assert property (p_pause_after)
        else $error("no pause");

    property p_addr;
        @(posedge sys_clk) disable iff (reset)
        !reset && (tens_address_switch == 4'h6
                   && ones_address_switch == 4'h5)
            |=> (address_invalid && lamps.net_act);
    endproperty
    a_addr: assert property (p_addr)
        else $error("65 accepted");

    property p_zero;
        @(posedge sys_clk) disable iff (reset)
        !reset && (tens_address_switch == 4'h0)
        && (ones_address_switch == 4'h0)
            |=> (address_invalid && lamps.net_act);
    endproperty
    a_zero: assert property (p_zero)
        else $error("0 accepted");

    property p_ascii;
        @(posedge sys_clk) disable iff (reset)
        !reset && (comm_switch == psc_pkg::PSC_POS_TOP) |=>
            (port_cfg.baud == psc_pkg::BAUD_ASCII) && bridge_mode;
    endproperty
    a_ascii: assert property (p_ascii)
        else $error("ascii cfg");

    property p_rtu;
        @(posedge sys_clk) disable iff (reset)
        !reset && (comm_switch == psc_pkg::PSC_POS_MIDDLE) |=>
            (port_cfg.baud == psc_pkg::BAUD_RTU)
            && (port_cfg.data_bits == psc_pkg::BITS_RTU) && bridge_mode;
    endproperty
    a_rtu: assert property (p_rtu)
        else $error("rtu cfg");

    // Refused software settings keep the last accepted ones
    property p_sw_refuse;
        @(posedge sys_clk) disable iff (reset)
        !reset && (comm_switch == psc_pkg::PSC_POS_BOTTOM) && !sw_ok |=>
            sw_cfg_invalid && (port_cfg == $past(port_cfg));
    endproperty
    a_sw_refuse: assert property (p_sw_refuse)
        else $error("bad software cfg taken");
endmodule

// File: bench/psc_front_panel.sv
// Front panel model: slide and rotary switches, lamp observer
`timescale 1ns/1ps
module psc_front_panel (
    input  wire logic                sys_clk,
    input  wire psc_pkg::psc_lamps_s lamps,
    output logic [1:0]               protect_switch,
    output logic [1:0]               comm_switch,
    output logic [3:0]               tens_address_switch,
    output logic [3:0]               ones_address_switch,
    output logic [2:0]               lit_count
);
    // Detented positions, valid from time zero
    initial begin
        protect_switch      = 2'h1;
        comm_switch         = 2'h0;
        tens_address_switch = 4'h1;
        ones_address_switch = 4'h1;
    end

    // Caller has just passed a rising edge
    task automatic set_sw(input logic [1:0] p, input logic [1:0] c,
                          input logic [3:0] t, input logic [3:0] o);
        protect_switch      <= p;
        comm_switch         <= c;
        tens_address_switch <= t;
        ones_address_switch <= o;
    endtask

    assign lit_count = 3'($countones(lamps));
endmodule

// File: bench/psc_panel_tb.sv
// Self-checking bench for the panel status and port config block
`timescale 1ns/1ps
module psc_panel_tb;
    logic                sys_clk = 1'b0;
    logic                reset   = 1'b1;
    logic                diag_passed = 1'b0, program_running = 1'b0;
    logic                serial_traffic = 1'b0, network_traffic = 1'b0;
    logic                battery_low = 1'b0, network_error = 1'b0;
    logic                fatal_error = 1'b0;
    logic [15:0]         crash_code  = 16'h0000;
    logic [1:0]          protect_switch, comm_switch;
    logic [3:0]          tens_address_switch, ones_address_switch;
    psc_pkg::psc_port_s  sw_port_cfg = '0, cfg_nxt = '0, exp_port;
    psc_pkg::psc_lamps_s lamps, exp_lamps;
    psc_pkg::psc_port_s  port_cfg;
    logic                mem_write_block, sw_cfg_invalid, bridge_mode;
    logic                address_invalid;
    logic [6:0]          node_address;
    logic [3:0]          blink_count;
    logic [2:0]          lit_count;
    int                  n_mismatch = 0, tests_run = 0, cycles = 0;
    logic [3:0]  ten_t [8] = '{4'h0,4'h0,4'h6,4'h6,4'h1,4'h9,4'h2,4'h5};
    logic [3:0]  one_t [8] = '{4'h1,4'h0,4'h4,4'h5,4'h1,4'h9,4'hA,4'h0};
    logic        inv_t [8] = '{1'b0,1'b1,1'b0,1'b1,1'b0,1'b1,1'b1,1'b0};
    logic [15:0] cc_t [18] = '{16'h0000,16'h080B,16'h080C,16'h082E,
        16'h0769,16'h072A,16'h0730,16'h0604,16'h0631,16'h0503,16'h052D,
        16'h0402,16'h0300,16'h0301,16'h8001,16'h8002,16'h8003,16'h0123};
    logic [3:0]  bc_t [18] = '{4'h0,4'h2,4'h2,4'h2,4'h3,4'h3,4'h3,4'h4,
        4'h4,4'h5,4'h5,4'h6,4'h7,4'h7,4'h8,4'h8,4'h8,4'h0};
    psc_pkg::psc_port_s sw_t [5];
    logic        swbad_t [5] = '{1'b0,1'b0,1'b1,1'b1,1'b1};

    always #12.5 sys_clk = ~sys_clk;

    psc_front_panel psc_front_panel_inst (.sys_clk(sys_clk), .lamps(lamps),
        .protect_switch(protect_switch), .comm_switch(comm_switch),
        .tens_address_switch(tens_address_switch),
        .ones_address_switch(ones_address_switch), .lit_count(lit_count));

    psc_panel psc_panel_inst (.sys_clk(sys_clk), .reset(reset),
        .diag_passed(diag_passed), .program_running(program_running),
        .serial_traffic(serial_traffic), .network_traffic(network_traffic),
        .battery_low(battery_low), .network_error(network_error),
        .fatal_error(fatal_error), .crash_code(crash_code),
        .protect_switch(protect_switch), .comm_switch(comm_switch),
        .tens_address_switch(tens_address_switch),
        .ones_address_switch(ones_address_switch),
        .sw_port_cfg(sw_port_cfg), .lamps(lamps),
        .mem_write_block(mem_write_block), .port_cfg(port_cfg),
        .sw_cfg_invalid(sw_cfg_invalid), .bridge_mode(bridge_mode),
        .node_address(node_address), .address_invalid(address_invalid),
        .blink_count(blink_count));

    task automatic fail(input string msg);
        n_mismatch++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask
    task automatic check_bit(input logic got, input logic exp, string m);
        tests_run++;
        if (got !== exp) fail(m);
    endtask
    task automatic check_num(input logic [7:0] got, exp, input string m);
        tests_run++;
        if (got !== exp) fail(m);
    endtask
    task automatic check_lamps(input psc_pkg::psc_lamps_s got, exp);
        tests_run++;
        if (got !== exp) fail("lamp pattern");
    endtask
    task automatic check_port(input psc_pkg::psc_port_s got, exp);
        tests_run++;
        if (got !== exp) fail("serial port settings");
    endtask

    // Drive everything just after an edge, let three edges land
    task automatic apply(input logic [5:0] st, input logic fe,
                         input logic [15:0] cc, input logic [1:0] p, c,
                         input logic [3:0] t, o);
        @(posedge sys_clk);
        {diag_passed, program_running, serial_traffic, network_traffic,
         battery_low, network_error} <= st;
        fatal_error <= fe;
        crash_code  <= cc;
        sw_port_cfg <= cfg_nxt;
        psc_front_panel_inst.set_sw(p, c, t, o);
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic summarize;
        $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_mismatch++;
            summarize();
        end
    end

    initial begin
        sw_t = '{'{15'h4B00, psc_pkg::PSC_PAR_ODD, 4'h8, 2'h2, 8'hF7},
                 '{15'h0032, psc_pkg::PSC_PAR_NONE, 4'h7, 2'h1, 8'h01},
                 '{15'h2580, psc_pkg::PSC_PAR_EVEN, 4'h8, 2'h1, 8'hF8},
                 '{15'h2580, psc_pkg::PSC_PAR_EVEN, 4'h8, 2'h1, 8'h00},
                 '{15'h0064, psc_pkg::PSC_PAR_EVEN, 4'h8, 2'h1, 8'h0B}};
        repeat (2) @(posedge sys_clk);
        #1;
        check_lamps(lamps, '0);
        check_port(port_cfg, '0);
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        // Each status input alone, then none, then all together
        for (int i = 0; i < 8; i++) begin
            logic [5:0] st;
            st = (i < 6) ? 6'(1 << i) : ((i == 6) ? 6'h00 : 6'h3F);
            apply(st, 1'b0, 16'h0000, 2'h1, 2'h0, 4'h1, 4'h1);
            exp_lamps = '{st[5], st[4], st[3], st[2], 1'b0, st[1], st[0]};
            check_lamps(lamps, exp_lamps);
            check_num({5'h0, lit_count}, 8'($countones(st)),
                      "lit lamps");
        end
        for (int p = 0; p < 3; p++) begin
            apply(6'h00, 1'b0, 16'h0000, 2'(p), 2'h0, 4'h1, 4'h1);
            check_bit(mem_write_block, p == 0, "protect");
            check_bit(lamps.mem_protect, p == 0, "amber");
        end
        for (int i = 0; i < 8; i++) begin
            apply(6'h00, 1'b0, 16'h0000, 2'h1, 2'h0, ten_t[i], one_t[i]);
            check_bit(address_invalid, inv_t[i], "address");
            check_bit(lamps.net_act, inv_t[i], "net lamp");
            if (one_t[i] <= 4'h9)
                check_num({1'b0, node_address},
                          8'(ten_t[i] * 10 + one_t[i]), "node");
        end
        apply(6'h00, 1'b0, 16'h0000, 2'h1, 2'h0, 4'h1, 4'h1);
        exp_port = '{15'h0960, psc_pkg::PSC_PAR_EVEN, 4'h7, 2'h1, 8'h0B};
        check_port(port_cfg, exp_port);
        check_bit(bridge_mode, 1'b1, "bridge ascii");
        apply(6'h00, 1'b0, 16'h0000, 2'h1, 2'h1, 4'h1, 4'h1);
        exp_port = '{15'h2580, psc_pkg::PSC_PAR_EVEN, 4'h8, 2'h1, 8'h0B};
        check_port(port_cfg, exp_port);
        check_bit(bridge_mode, 1'b1, "bridge rtu");
        // Refused settings leave the last accepted ones in force
        for (int i = 0; i < 5; i++) begin
            cfg_nxt = sw_t[i];
            apply(6'h00, 1'b0, 16'h0000, 2'h1, 2'h2, 4'h1, 4'h1);
            if (!swbad_t[i])
                exp_port = sw_t[i];
            check_port(port_cfg, exp_port);
            check_bit(sw_cfg_invalid, swbad_t[i], "sw cfg");
            check_bit(bridge_mode, 1'b0, "bridge sw");
        end
        for (int i = 0; i < 18; i++) begin
            apply(6'h00, 1'b0, cc_t[i], 2'h1, 2'h0, 4'h1, 4'h1);
            check_bit(lamps.run, 1'b0, "run idle");
            apply(6'h00, 1'b1, cc_t[i], 2'h1, 2'h0, 4'h1, 4'h1);
            check_bit(lamps.run, 1'b1, "blink on");
            check_num({4'h0, blink_count}, {4'h0, bc_t[i]},
                      "blink group");
        end
        summarize();
    end
endmodule
